/* core/sadc_readout.sv */
// Digital core of the 12-bit converter: SAR stepping, serial output, offset store and hand-over to sys_clk.
//
// Functional notes
// - Sampling switch holds the input from the frame select falling edge.
// - Host serial clock steps the conversion and shifts the result; no internal clock.
// - Inputs isolated during conversion, reconnected once a result conversion ends; after calibration only when frame select rises.
// - Comparator weighs positive minus negative input against the trial level.
// - Result is unsigned straight binary, lowest input all zeros.
// - Result has 12 bits; one step is reference over 4096.
// - Lowest step gives 000, half reference gives midpoint code 800.
// - Top of range saturates to highest scale code FFF.
// - Offset calibration at power-up or in a long frame, stored and applied.
// - Frame is two zero bits then 12 result bits, MSB first.
// - First zero at frame select fall, later bits on serial clock falling edges.
// - Output low after 14 clocks, high impedance when frame select rises.
// - First frame calibrates; output low; store updates only after 16 falling edges.
`timescale 1ns/1ps
module sadc_readout
  import sadc_pkg::*;
(
  // System clock and power-up reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Serial link from the host
  input  wire logic                  sclk,
  input  wire logic                  frame_sel_n,
  output logic                       sdo_o,
  output logic                       sdo_oe,
  // Analog front end
  input  wire logic                  cmp_above,
  output logic                       sample_hold,
  output logic                       input_connect,
  output logic                       zero_short,
  output logic [SADC_RES_W-1:0]      dac_code,
  // System side view of results
  output logic [SADC_RES_W-1:0]      result_data,
  output logic                       result_valid,
  output logic                       cal_done
);

  // Link domain, rising edge: SAR stepping, cleared by the frame select.
  logic [SADC_CNT_W-1:0] rcnt_q, rcnt_d;
  logic [SADC_RES_W-1:0] trial_q, trial_d, mask_q, mask_d, res_q, res_d;
  logic                  recal_q, recal_d;
  // Link domain, falling edge: frame bit counter and output bit.
  logic [SADC_CNT_W-1:0] fcnt_q, fcnt_d;
  logic                  fcal_q, fcal_d, sdo_q, sdo_d;
  // Link domain, falling edge: state kept across frames.
  logic [SADC_RES_W-1:0] ofs_q, ofs_d, word_q, word_d;
  logic                  pend_q, pend_d, tog_q, tog_d;
  // System domain.
  logic                  tog_s1_q, tog_s2_q, tog_s3_q, pend_s1_q, pend_s2_q;
  logic [SADC_RES_W-1:0] result_q, result_d;
  logic                  valid_q, valid_d;
  logic [SADC_RES_W:0]   dac_sum;

  assign sample_hold = ~frame_sel_n;
  assign sdo_oe      = ~frame_sel_n;
  assign sdo_o       = sdo_q;
  assign zero_short  = fcal_q | recal_q;
  assign input_connect = frame_sel_n | (~fcal_q & ~recal_q & (rcnt_q >= SADC_CONV_STEPS));

  // Saturation means the store only corrects a positive offset; a negative one reads as zero.
  // Apply stored offset.
  always_comb begin
    dac_sum = {1'b0, trial_q} + (zero_short ? {1'b0, SADC_OFS_RST} : {1'b0, ofs_q});
    dac_code = dac_sum[SADC_RES_W] ? SADC_HIGH_CODE : dac_sum[SADC_RES_W-1:0];
  end

  // The comparator is strobed by the analog stage on the rising serial clock edge, so it already
  // belongs to this domain; a synchroniser here would cost a whole bit time per decision.
  always_comb begin
    rcnt_d  = rcnt_q;
    trial_d = trial_q;
    mask_d  = mask_q;
    res_d   = res_q;
    recal_d = recal_q;
    if (fcnt_q != '0) begin
      if (rcnt_q != SADC_CNT_MAX) begin
        rcnt_d = rcnt_q + 6'h01;
      end
      if (!fcal_q && !recal_q && rcnt_q == SADC_RECAL_LOAD) begin
        trial_d = SADC_MID_CODE;
        mask_d  = SADC_MID_CODE;
        res_d   = SADC_LOW_CODE;
        recal_d = 1'b1;
      end else if (mask_q != '0) begin
        res_d   = cmp_above ? (res_q | mask_q) : res_q;
        mask_d  = mask_q >> 1;
        trial_d = res_d | (mask_q >> 1);
      end
    end
  end

  // Frame select high clears per-frame state at once, so a cut frame never leaks into the next.
  // Stepped by serial clock.
  always_ff @(posedge sclk or posedge frame_sel_n or negedge rst_n) begin
    if (!rst_n || frame_sel_n) begin
      rcnt_q  <= '0;
      trial_q <= SADC_MID_CODE;
      mask_q  <= SADC_MID_CODE;
      res_q   <= SADC_LOW_CODE;
      recal_q <= 1'b0;
    end else begin
      rcnt_q  <= rcnt_d;
      trial_q <= trial_d;
      mask_q  <= mask_d;
      res_q   <= res_d;
      recal_q <= recal_d;
    end
  end

  // The frame counter saturates, so a very long frame keeps the output low.
  always_comb begin
    fcnt_d = (fcnt_q == SADC_CNT_MAX) ? fcnt_q : fcnt_q + 6'h01;
    fcal_d = (fcnt_q == '0) ? pend_q : fcal_q;
    sdo_d  = 1'b0;
    if (!fcal_d && fcnt_q >= SADC_DATA_F_LO && fcnt_q <= SADC_LAST_BIT_F) begin
      sdo_d = res_q[4'(SADC_LAST_BIT_F - fcnt_q)];
    end
  end

  // Bits change on the falling edge, so they are settled long before the host takes them.
  // Launch on falling edges.
  always_ff @(negedge sclk or posedge frame_sel_n or negedge rst_n) begin
    if (!rst_n || frame_sel_n) begin
      fcnt_q <= '0;
      fcal_q <= 1'b0;
      sdo_q  <= 1'b0;
    end else begin
      fcnt_q <= fcnt_d;
      fcal_q <= fcal_d;
      sdo_q  <= sdo_d;
    end
  end

  // Pending clears at the first falling edge, so a cut calibration frame is never retried.
  always_comb begin
    ofs_d  = ofs_q;
    pend_d = (fcnt_q == '0) ? 1'b0 : pend_q;
    word_d = word_q;
    tog_d  = tog_q;
    if (fcal_q && fcnt_q == SADC_CAL_DONE_F) begin
      ofs_d = res_q;
    end
    // A frame cut before the last edge leaves the old offset in place.
    // Store after thirty-two edges.
    if (recal_q && mask_q == '0 && fcnt_q == SADC_RECAL_DONE) begin
      ofs_d = res_q;
    end
    if (!fcal_q && fcnt_q == SADC_LAST_BIT_F) begin
      word_d = res_q;
      tog_d  = ~tog_q;
    end
  end

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      ofs_q  <= SADC_OFS_RST;
      pend_q <= 1'b1;
      word_q <= SADC_LOW_CODE;
      tog_q  <= 1'b0;
    end else begin
      ofs_q  <= ofs_d;
      pend_q <= pend_d;
      word_q <= word_d;
      tog_q  <= tog_d;
    end
  end

  // The word stays still for a whole frame after the toggle, so it is safe to take it once the
  // synchronised toggle shows a change.
  always_comb begin
    valid_d  = tog_s2_q ^ tog_s3_q;
    result_d = valid_d ? word_q : result_q;
  end

  // Only stages after the first feed logic (pend_s2_q, tog_s2_q and tog_s3_q), so a metastable first stage stays contained.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1_q  <= 1'b0;
      tog_s2_q  <= 1'b0;
      tog_s3_q  <= 1'b0;
      pend_s1_q <= 1'b1;
      pend_s2_q <= 1'b1;
      result_q  <= SADC_LOW_CODE;
      valid_q   <= 1'b0;
    end else begin
      tog_s1_q  <= tog_q;
      tog_s2_q  <= tog_s1_q;
      tog_s3_q  <= tog_s2_q;
      pend_s1_q <= pend_q;
      pend_s2_q <= pend_s1_q;
      result_q  <= result_d;
      valid_q   <= valid_d;
    end
  end

  // Pending is a slow level that settles once per power-up, so two flip-flops suffice for it.
  assign result_data  = result_q;
  assign result_valid = valid_q;
  assign cal_done     = ~pend_s2_q;

endmodule // sadc_readout

/* core/sadc_pkg.sv */
// Constants shared by the serial readout of the successive-approximation converter.
package sadc_pkg;
  localparam int unsigned SADC_RES_W     = 12;
  localparam int unsigned SADC_CNT_W     = 6;
  localparam logic [11:0] SADC_MID_CODE  = 12'h800;
  localparam logic [11:0] SADC_LOW_CODE  = 12'h000;
  localparam logic [11:0] SADC_HIGH_CODE = 12'hfff;
  localparam logic [11:0] SADC_OFS_RST   = 12'h000;
  localparam logic [5:0]  SADC_CNT_MAX   = 6'h3f;
  localparam logic [5:0]  SADC_CONV_STEPS = 6'h0c;
  localparam logic [5:0]  SADC_LAST_BIT_F = 6'h0c;
  localparam logic [5:0]  SADC_DATA_F_LO  = 6'h01;
  localparam logic [5:0]  SADC_RECAL_LOAD = 6'h0f;
  localparam logic [5:0]  SADC_CAL_DONE_F = 6'h0f;
  localparam logic [5:0]  SADC_RECAL_DONE = 6'h1f;
endpackage

/* test/sadc_readout_sva.sv */
// Port assertions for the serial readout core.
`timescale 1ns/1ps
module sadc_readout_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic frame_sel_n,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sample_hold,
  input wire logic input_connect,
  input wire logic zero_short,
  input wire logic result_valid,
  input wire logic cal_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence one_pulse;
    result_valid ##1 !result_valid;
  endsequence
  hold_sel_a: assert property (sample_hold == !frame_sel_n) else $error("hold wrong");
  oe_frame_a: assert property (sdo_oe == !frame_sel_n) else $error("enable wrong");
  idle_low_a: assert property (frame_sel_n |-> !sdo_o) else $error("data not low");
  start_iso_a: assert property ($fell(frame_sel_n) |-> !input_connect) else $error("not isolated");
  idle_conn_a: assert property (frame_sel_n |-> input_connect && !zero_short) else $error("not connected");
  short_iso_a: assert property (zero_short |-> !input_connect) else $error("short while connected");
  valid_once_a: assert property (result_valid |-> one_pulse) else $error("valid too long");
  cal_first_a: assert property (!cal_done |-> !result_valid) else $error("result before calibration");
endmodule // sadc_readout_sva
bind sadc_readout sadc_readout_sva i_sadc_readout_sva (
  .sys_clk       (sys_clk),
  .rst_n         (rst_n),
  .frame_sel_n   (frame_sel_n),
  .sdo_o         (sdo_o),
  .sdo_oe        (sdo_oe),
  .sample_hold   (sample_hold),
  .input_connect (input_connect),
  .zero_short    (zero_short),
  .result_valid  (result_valid),
  .cal_done      (cal_done)
);

/* test/sadc_host_model.sv */
// Host serial master model driving frame select and serial clock.
`timescale 1ns/1ps
module sadc_host_model (
  output logic      sclk        = 1'b1,
  output logic      frame_sel_n = 1'b1,
  input  wire logic sdo
);
  // Frames of n serial clocks of any length; keeps the first 14 bits and flags any later non-zero bit.
  // The serial clock stands high between frames, so the core never sees a stray edge.
  task automatic xfer(input int n, output logic [13:0] w, output logic late);
    {w, late} = 15'h0000;
    frame_sel_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #(i ? 6 : 12) if (i < 14) w = {w[12:0], sdo};
      late = late | (i > 13 && sdo !== 1'b0);
      sclk = 1'b0;
      #6 sclk = 1'b1;
    end
    #6 frame_sel_n = 1'b1;
  endtask
endmodule // sadc_host_model

/* test/sadc_readout_test.sv */
// Bench for the serial readout with host and comparator models.
`timescale 1ns/1ps
module sadc_readout_test;
  import sadc_pkg::*;
  logic        sys_clk    = 1'b0;
  logic        rst_n      = 1'b0;
  logic [11:0] vin        = 12'h000;
  int          error_cnt  = 0;
  int          num_checks = 0;
  wire         sclk, frame_sel_n, sdo_o, sdo_oe, sample_hold, input_connect, zero_short, result_valid, cal_done;
  wire  [11:0] dac_code, result_data;
  wire         cmp_above = zero_short ? 13'h5 >= {1'b0, dac_code} : {1'b0, vin} + 13'h5 >= {1'b0, dac_code};
  sadc_readout i_sadc_readout (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .sclk          (sclk),
    .frame_sel_n   (frame_sel_n),
    .sdo_o         (sdo_o),
    .sdo_oe        (sdo_oe),
    .cmp_above     (cmp_above),
    .sample_hold   (sample_hold),
    .input_connect (input_connect),
    .zero_short    (zero_short),
    .dac_code      (dac_code),
    .result_data   (result_data),
    .result_valid  (result_valid),
    .cal_done      (cal_done)
  );
  sadc_host_model i_sadc_host_model (.sclk(sclk), .frame_sel_n(frame_sel_n), .sdo(sdo_oe ? sdo_o : 1'bz));
  initial forever #4 sys_clk = ~sys_clk;
  initial #25 rst_n = 1'b1;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    error_cnt += int'(got !== exp);
    if (got !== exp) $display("Error at %0t: got %h exp %h", $time, got, exp);
  endtask
  task automatic conv(input int n, input logic [11:0] v, input logic [11:0] bits, input logic [11:0] data);
    logic [13:0] w;
    logic        late;
    repeat (5) @(posedge sys_clk);
    #1 vin = v;
    i_sadc_host_model.xfer(n, w, late);
    check({1'b0, late, w}, {4'h0, bits});
    check({4'h0, result_data}, {4'h0, data});
  endtask
  task automatic t_late_cal();
    conv(4, 12'h100, 12'h000, 12'h000);
    conv(32, 12'h100, 12'h105, 12'h105);
    conv(16, 12'h200, 12'h200, 12'h200);
    $display("test late_cal done");
  endtask
  task automatic t_powerup_cal();
    @(posedge sys_clk) #1 rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    check({15'h0000, cal_done}, 16'h0000);
    conv(16, 12'h3a0, 12'h000, 12'h000);
    check({15'h0000, cal_done}, 16'h0001);
    $display("test powerup_cal done");
  endtask
  task automatic t_codes();
    logic [11:0] tbl [5] = '{12'h000, 12'h001, 12'h800, 12'h801, 12'hfff};
    foreach (tbl[i]) conv(16, tbl[i], tbl[i], tbl[i]);
    $display("test codes done");
  endtask
  initial begin
    t_late_cal();
    t_powerup_cal();
    t_codes();
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule // sadc_readout_test
